// ==== hw/memspace_cfg.svh ====
// Address map, vector and stepping constants of the memory space decoder
`ifndef MEMSPACE_CFG_SVH
`define MEMSPACE_CFG_SVH

// Program space layout
`define MS_PC_RESET      24'h000000
`define MS_RESET_TARGET  24'h000002
`define MS_IVT_BASE      24'h000004
`define MS_IVT_LAST      24'h0000ff
`define MS_ALT_BASE      24'h000100
`define MS_ALT_LAST      24'h0001ff
`define MS_VECTOR_END    24'h000200
`define MS_PC_STEP       24'h000002
`define MS_UPPER_WORD    24'h000001

// Data space layout
`define MS_SFR_END       17'h00800
`define MS_NEAR_END      17'h02000
`define MS_RAM_BYTES     16384
`define MS_RAM_AW        13
`define MS_WIN_BIT       15

// Pointer steps per operand size
`define MS_BYTE_STEP     16'h0001
`define MS_WORD_STEP     16'h0002

`endif

// ==== hw/memspace_pkg.sv ====
// Types shared by the memory space decoder modules
package memspace_pkg;

   // How an effective address is formed
   typedef enum logic [1:0] {
      ea_direct,
      ea_near,
      ea_indirect
   } ea_mode_t;

   // Which target answers a data access
   typedef enum logic [1:0] {
      src_zero,
      src_ram,
      src_sfr,
      src_window
   } data_src_t;

   // Working register update kinds
   typedef enum logic [1:0] {
      wreg_pass,
      wreg_byte_load,
      wreg_sign_extend,
      wreg_zero_extend
   } wreg_op_t;

endpackage

// ==== hw/mem_lane_if.sv ====
// One byte-wide lane of data RAM: separate read and write ports
`timescale 1ns/1ps
interface mem_lane_if #(parameter int AW = 13);
   logic [AW-1:0] rd_addr;
   logic [AW-1:0] wr_addr;
   logic          we;
   logic [7:0]    wdata;
   logic [7:0]    rdata;

   modport ctrl (output rd_addr, output wr_addr, output we, output wdata, input rdata);
   modport mem  (input rd_addr, input wr_addr, input we, input wdata, output rdata);
endinterface

// ==== hw/byte_lane.sv ====
// Byte-wide RAM lane with registered read and its own write strobe
`timescale 1ns/1ps
module byte_lane #(
   parameter int AW = 13
) (
   input  wire logic clk,
   mem_lane_if.mem   port
);
   logic [7:0] mem_array [0:(1<<AW)-1];
   logic [7:0] rdata_reg;

   // Write only when this lane is strobed
   always_ff @(posedge clk) begin
      if (port.we) begin
         mem_array[port.wr_addr] <= port.wdata;
      end
   end

   // Synchronous read of the addressed byte
   always_ff @(posedge clk) begin
      rdata_reg <= mem_array[port.rd_addr];
   end

   assign port.rdata = rdata_reg;
endmodule // byte_lane

// ==== hw/pc_unit.sv ====
// Program counter with word stepping and vector area decode
`timescale 1ns/1ps
`include "memspace_cfg.svh"
module pc_unit (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        step,
   input  wire logic        step_down,
   input  wire logic        load,
   input  wire logic [23:0] load_addr,
   output logic      [23:0] pc,
   output logic      [23:0] upper_word_addr,
   output logic             in_vector_area,
   output logic             in_ivt,
   output logic             in_alt_ivt
);
   logic [23:0] pc_reg;
   logic [23:0] pc_next;
   logic        vec_reg;
   logic        ivt_reg;
   logic        alt_reg;

   // Next program address, always on the lower word
   always_comb begin
      pc_next = pc_reg;
      if (load) begin
         pc_next = {load_addr[23:1], 1'b0};
      end else if (step && step_down) begin
         pc_next = pc_reg - `MS_PC_STEP;
      end else if (step) begin
         pc_next = pc_reg + `MS_PC_STEP;
      end
   end

   // Counter starts at the reset vector
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pc_reg <= `MS_PC_RESET;
      end else begin
         pc_reg <= pc_next;
      end
   end

   // Vector area flags follow the counter
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         vec_reg <= 1'b1;
         ivt_reg <= 1'b0;
         alt_reg <= 1'b0;
      end else begin
         vec_reg <= pc_next < `MS_VECTOR_END;
         ivt_reg <= pc_next >= `MS_IVT_BASE && pc_next <= `MS_IVT_LAST;
         alt_reg <= pc_next >= `MS_ALT_BASE && pc_next <= `MS_ALT_LAST;
      end
   end

   assign pc              = pc_reg;
   assign upper_word_addr = pc_reg | `MS_UPPER_WORD;
   assign in_vector_area  = vec_reg;
   assign in_ivt          = ivt_reg;
   assign in_alt_ivt      = alt_reg;

   // Forward step moves by one instruction word
   AST_PC_STEP_UP: assert property (@(posedge clk) disable iff (!arst_n)
      step && !step_down && !load |=> pc == $past(pc) + `MS_PC_STEP)
      else $error("pc did not advance by two");

   // Counter never leaves the lower word
   AST_PC_ALIGNED: assert property (@(posedge clk) disable iff (!arst_n)
      pc[0] == 1'b0)
      else $error("pc is on an odd address");

   // Alternate table flag matches its range
   AST_ALT_FLAG: assert property (@(posedge clk) disable iff (!arst_n)
      in_alt_ivt == (pc >= `MS_ALT_BASE && pc <= `MS_ALT_LAST))
      else $error("alternate table flag wrong");
endmodule // pc_unit

// ==== hw/memspace_decode.sv ====
// Top of the memory space decoder: data address decode, lanes, trap, program counter
// What this block does
// - Program location is lower plus upper word
// - Program counter word aligned, steps by two
// - Addresses below 0x000200 hold fixed vectors
// - Execution starts at zero, target at two
// - Two interrupt vector tables in vector area
// - Data space separate, own read/write generators
// - Effective address is sixteen bits, byte granular
// - Top address bit selects program window
// - Unimplemented data reads return zero
// - Low byte even, high byte odd
// - Post-modify steps one byte, two word
// - Byte read selects byte onto low lane
// - Shared word decode, per-lane write strobes
// - Odd word access raises address error trap
// - Misaligned read completes, misaligned write suppressed
// - Byte load changes only low byte
// - Sign extend and zero extend of byte
// - First 2 Kbytes are special registers
// - Unused special register addresses read zero
// - Near region reached by thirteen-bit field
// - Whole space via direct or pointer
// - Window enable shows program space upstairs
`timescale 1ns/1ps
`include "memspace_cfg.svh"
module memspace_decode #(
   parameter int RAM_BYTES = `MS_RAM_BYTES
) (
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   // Program counter control
   input  wire logic                   pc_step,
   input  wire logic                   pc_step_down,
   input  wire logic                   pc_load,
   input  wire logic [23:0]            pc_load_addr,
   output logic      [23:0]            pc_addr,
   output logic      [23:0]            pc_upper_addr,
   output logic                        pc_in_vector_area,
   output logic                        pc_in_ivt,
   output logic                        pc_in_alt_ivt,
   // Window enable
   input  wire logic                   window_enable,
   // Read address generation
   input  wire logic                   rd_req,
   input  wire logic                   rd_byte,
   input  wire memspace_pkg::ea_mode_t rd_mode,
   input  wire logic [15:0]            rd_direct,
   input  wire logic [12:0]            rd_near,
   input  wire logic [15:0]            rd_ptr,
   input  wire logic                   rd_post_inc,
   input  wire logic                   rd_post_dec,
   output logic      [15:0]            rd_ptr_next,
   output logic      [15:0]            rd_data,
   output logic                        rd_valid,
   // Write address generation
   input  wire logic                   wr_req,
   input  wire logic                   wr_byte,
   input  wire memspace_pkg::ea_mode_t wr_mode,
   input  wire logic [15:0]            wr_direct,
   input  wire logic [12:0]            wr_near,
   input  wire logic [15:0]            wr_ptr,
   input  wire logic                   wr_post_inc,
   input  wire logic                   wr_post_dec,
   input  wire logic [15:0]            wr_data,
   output logic      [15:0]            wr_ptr_next,
   // Special register area
   output logic                        sfr_rd,
   output logic      [10:0]            sfr_rd_addr,
   input  wire logic [15:0]            sfr_rd_data,
   input  wire logic                   sfr_rd_hit,
   output logic                        sfr_wr,
   output logic      [10:0]            sfr_wr_addr,
   output logic      [1:0]             sfr_wr_be,
   output logic      [15:0]            sfr_wr_data,
   // Program window
   output logic                        win_rd,
   output logic      [14:0]            win_rd_addr,
   input  wire logic [15:0]            win_rd_data,
   // Trap request
   output logic                        addr_error_trap,
   output logic                        addr_error_on_write,
   // Working register byte update
   input  wire logic                   wreg_req,
   input  wire memspace_pkg::wreg_op_t wreg_op,
   input  wire logic [15:0]            wreg_old,
   input  wire logic [7:0]             wreg_byte,
   output logic      [15:0]            wreg_new,
   output logic                        wreg_valid
);
   localparam int          AW        = `MS_RAM_AW;
   localparam logic [16:0] RAM_LIMIT = 17'(RAM_BYTES);

   memspace_pkg::data_src_t rd_src;
   memspace_pkg::data_src_t wr_src;
   memspace_pkg::data_src_t rd_src_reg;
   logic [15:0] rd_ea;
   logic [15:0] wr_ea;
   logic        rd_mis;
   logic        wr_mis;
   logic        rd_go;
   logic        wr_go;
   logic        rd_stage_reg;
   logic        rd_odd_reg;
   logic        rd_byte_reg;
   logic        rd_bad_reg;
   logic [15:0] rd_word;
   logic [15:0] rd_data_reg;
   logic        rd_valid_reg;
   logic [15:0] rd_ptr_reg;
   logic [15:0] wr_ptr_reg;
   logic        sfr_rd_reg;
   logic [10:0] sfr_rd_addr_reg;
   logic        sfr_wr_reg;
   logic [10:0] sfr_wr_addr_reg;
   logic [1:0]  sfr_wr_be_reg;
   logic [15:0] sfr_wr_data_reg;
   logic        win_rd_reg;
   logic [14:0] win_rd_addr_reg;
   logic        trap_reg;
   logic        trap_wr_reg;
   logic [15:0] wreg_new_reg;
   logic        wreg_valid_reg;
   logic [1:0]  lane_sel;
   logic [7:0]  hi_wdata;

   mem_lane_if #(.AW(AW)) lo_if ();
   mem_lane_if #(.AW(AW)) hi_if ();

   // Effective address from direct, near or pointer mode
   function automatic logic [15:0] ea_calc(input memspace_pkg::ea_mode_t mode,
                                           input logic [15:0] direct,
                                           input logic [12:0] near,
                                           input logic [15:0] ptr);
      logic [15:0] ea;
      ea = ptr;
      if (mode == memspace_pkg::ea_direct) begin
         ea = direct;
      end else if (mode == memspace_pkg::ea_near) begin
         ea = {3'h0, near};
      end
      return ea;
   endfunction

   // Pointer post-modify scaled by operand size
   function automatic logic [15:0] ptr_step(input logic [15:0] ptr, input logic is_byte,
                                            input logic inc, input logic dec);
      logic [15:0] amount;
      logic [15:0] res;
      amount = is_byte ? `MS_BYTE_STEP : `MS_WORD_STEP;
      res    = ptr;
      if (inc) begin
         res = ptr + amount;
      end else if (dec) begin
         res = ptr - amount;
      end
      return res;
   endfunction

   // Which target an address belongs to
   function automatic memspace_pkg::data_src_t classify(input logic [15:0] ea,
                                                        input logic win_en);
      memspace_pkg::data_src_t src;
      src = memspace_pkg::src_zero;
      if (ea[`MS_WIN_BIT]) begin
         if (win_en) begin
            src = memspace_pkg::src_window;
         end
      end else if ({1'b0, ea} < `MS_SFR_END) begin
         src = memspace_pkg::src_sfr;
      end else if ({1'b0, ea} < RAM_LIMIT) begin
         src = memspace_pkg::src_ram;
      end
      return src;
   endfunction

   // Independent read and write address generation
   assign rd_ea  = ea_calc(rd_mode, rd_direct, rd_near, rd_ptr);
   assign wr_ea  = ea_calc(wr_mode, wr_direct, wr_near, wr_ptr);
   assign rd_src = classify(rd_ea, window_enable);
   assign wr_src = classify(wr_ea, window_enable);
   assign rd_mis = rd_req && !rd_byte && rd_ea[0];
   assign wr_mis = wr_req && !wr_byte && wr_ea[0];
   assign rd_go  = rd_req && !rd_mis;
   assign wr_go  = wr_req && !wr_mis;

   // Shared word address, per-lane write strobes
   assign lane_sel       = wr_byte ? {wr_ea[0], !wr_ea[0]} : 2'h3;
   assign hi_wdata       = wr_byte ? wr_data[7:0] : wr_data[15:8];
   assign lo_if.rd_addr  = rd_ea[AW:1];
   assign hi_if.rd_addr  = rd_ea[AW:1];
   assign lo_if.wr_addr  = wr_ea[AW:1];
   assign hi_if.wr_addr  = wr_ea[AW:1];
   assign lo_if.we       = wr_go && wr_src == memspace_pkg::src_ram && lane_sel[0];
   assign hi_if.we       = wr_go && wr_src == memspace_pkg::src_ram && lane_sel[1];
   assign lo_if.wdata    = wr_data[7:0];
   assign hi_if.wdata    = hi_wdata;

   byte_lane #(.AW(AW)) u_lane_lo (
      .clk  (clk),
      .port (lo_if)
   );

   byte_lane #(.AW(AW)) u_lane_hi (
      .clk  (clk),
      .port (hi_if)
   );

   // First read stage: remember target and byte position
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_stage_reg <= 1'b0;
         rd_src_reg   <= memspace_pkg::src_zero;
         rd_odd_reg   <= 1'b0;
         rd_byte_reg  <= 1'b0;
         rd_bad_reg   <= 1'b0;
      end else begin
         rd_stage_reg <= rd_req;
         rd_src_reg   <= rd_src;
         rd_odd_reg   <= rd_ea[0];
         rd_byte_reg  <= rd_byte;
         rd_bad_reg   <= rd_mis;
      end
   end

   // Word seen by the second stage
   always_comb begin
      rd_word = 16'h0000;
      if (rd_src_reg == memspace_pkg::src_ram) begin
         rd_word = {hi_if.rdata, lo_if.rdata};
      end else if (rd_src_reg == memspace_pkg::src_sfr && sfr_rd_hit) begin
         rd_word = sfr_rd_data;
      end else if (rd_src_reg == memspace_pkg::src_window) begin
         rd_word = win_rd_data;
      end
   end

   // Second read stage: byte select onto low lane
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data_reg  <= 16'h0000;
         rd_valid_reg <= 1'b0;
      end else begin
         rd_valid_reg <= rd_stage_reg;
         if (rd_bad_reg) begin
            rd_data_reg <= 16'h0000;
         end else if (rd_byte_reg) begin
            rd_data_reg <= {8'h00, rd_odd_reg ? rd_word[15:8] : rd_word[7:0]};
         end else begin
            rd_data_reg <= rd_word;
         end
      end
   end

   // Special register and window strobes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sfr_rd_reg      <= 1'b0;
         sfr_rd_addr_reg <= 11'h000;
         win_rd_reg      <= 1'b0;
         win_rd_addr_reg <= 15'h0000;
         sfr_wr_reg      <= 1'b0;
         sfr_wr_addr_reg <= 11'h000;
         sfr_wr_be_reg   <= 2'h0;
         sfr_wr_data_reg <= 16'h0000;
      end else begin
         sfr_rd_reg      <= rd_go && rd_src == memspace_pkg::src_sfr;
         sfr_rd_addr_reg <= {rd_ea[10:1], 1'b0};
         win_rd_reg      <= rd_go && rd_src == memspace_pkg::src_window;
         win_rd_addr_reg <= {rd_ea[14:1], 1'b0};
         sfr_wr_reg      <= wr_go && wr_src == memspace_pkg::src_sfr;
         sfr_wr_addr_reg <= {wr_ea[10:1], 1'b0};
         sfr_wr_be_reg   <= lane_sel;
         sfr_wr_data_reg <= {hi_wdata, wr_data[7:0]};
      end
   end

   // Address error trap, one registered pulse
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         trap_reg    <= 1'b0;
         trap_wr_reg <= 1'b0;
      end else begin
         trap_reg    <= rd_mis || wr_mis;
         trap_wr_reg <= wr_mis;
      end
   end

   // Post-modified pointers of both generators
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_ptr_reg <= 16'h0000;
         wr_ptr_reg <= 16'h0000;
      end else begin
         rd_ptr_reg <= ptr_step(rd_ptr, rd_byte, rd_post_inc, rd_post_dec);
         wr_ptr_reg <= ptr_step(wr_ptr, wr_byte, wr_post_inc, wr_post_dec);
      end
   end

   // Working register byte load and extension
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wreg_new_reg   <= 16'h0000;
         wreg_valid_reg <= 1'b0;
      end else begin
         wreg_valid_reg <= wreg_req;
         case (wreg_op)
            memspace_pkg::wreg_byte_load: begin
               wreg_new_reg <= {wreg_old[15:8], wreg_byte};
            end
            memspace_pkg::wreg_sign_extend: begin
               wreg_new_reg <= {{8{wreg_old[7]}}, wreg_old[7:0]};
            end
            memspace_pkg::wreg_zero_extend: begin
               wreg_new_reg <= {8'h00, wreg_old[7:0]};
            end
            default: begin
               wreg_new_reg <= wreg_old;
            end
         endcase
      end
   end

   pc_unit u_pc (
      .clk             (clk),
      .arst_n          (arst_n),
      .step            (pc_step),
      .step_down       (pc_step_down),
      .load            (pc_load),
      .load_addr       (pc_load_addr),
      .pc              (pc_addr),
      .upper_word_addr (pc_upper_addr),
      .in_vector_area  (pc_in_vector_area),
      .in_ivt          (pc_in_ivt),
      .in_alt_ivt      (pc_in_alt_ivt)
   );

   assign rd_data             = rd_data_reg;
   assign rd_valid            = rd_valid_reg;
   assign rd_ptr_next         = rd_ptr_reg;
   assign wr_ptr_next         = wr_ptr_reg;
   assign sfr_rd              = sfr_rd_reg;
   assign sfr_rd_addr         = sfr_rd_addr_reg;
   assign sfr_wr              = sfr_wr_reg;
   assign sfr_wr_addr         = sfr_wr_addr_reg;
   assign sfr_wr_be           = sfr_wr_be_reg;
   assign sfr_wr_data         = sfr_wr_data_reg;
   assign win_rd              = win_rd_reg;
   assign win_rd_addr         = win_rd_addr_reg;
   assign addr_error_trap     = trap_reg;
   assign addr_error_on_write = trap_wr_reg;
   assign wreg_new            = wreg_new_reg;
   assign wreg_valid          = wreg_valid_reg;

   // Odd word access gives exactly one trap pulse
   AST_TRAP_PULSE: assert property (@(posedge clk) disable iff (!arst_n)
      (rd_mis || wr_mis) |=> addr_error_trap ##1 (!addr_error_trap || $past(rd_mis || wr_mis)))
      else $error("address error trap not a single pulse");

   // Misaligned write never reaches memory
   AST_NO_MIS_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
      wr_mis |-> !lo_if.we && !hi_if.we ##1 !sfr_wr)
      else $error("misaligned write was performed");

   // Every read completes two cycles later
   AST_READ_DONE: assert property (@(posedge clk) disable iff (!arst_n)
      rd_req |-> ##2 rd_valid)
      else $error("read did not complete");

   // Byte read leaves upper lane zero
   AST_BYTE_READ_LOW: assert property (@(posedge clk) disable iff (!arst_n)
      rd_req && rd_byte |-> ##2 rd_data[15:8] == 8'h00)
      else $error("byte read not on low lane");

   // Unimplemented or hidden addresses read zero
   AST_UNIMPL_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
      rd_req && rd_src == memspace_pkg::src_zero |-> ##2 rd_data == 16'h0000)
      else $error("unimplemented address read nonzero");

   // Byte write strobes one lane only
   AST_BYTE_ONE_LANE: assert property (@(posedge clk) disable iff (!arst_n)
      wr_req && wr_byte |-> !(lo_if.we && hi_if.we) && (hi_if.we == 1'b0 || wr_ea[0]))
      else $error("byte write hit wrong lane");

   // Word post-increment adds two
   AST_PTR_WORD_STEP: assert property (@(posedge clk) disable iff (!arst_n)
      !rd_byte && rd_post_inc |=> rd_ptr_next == $past(rd_ptr) + `MS_WORD_STEP)
      else $error("word post increment wrong");

   // Window strobe only with enable set
   AST_WINDOW_GATE: assert property (@(posedge clk) disable iff (!arst_n)
      win_rd |-> $past(window_enable) && $past(rd_ea[`MS_WIN_BIT]))
      else $error("window read without enable");

   // Sign extension copies bit seven upward
   AST_SIGN_EXT: assert property (@(posedge clk) disable iff (!arst_n)
      wreg_op == memspace_pkg::wreg_sign_extend |=>
         wreg_new == {{8{$past(wreg_old[7])}}, $past(wreg_old[7:0])})
      else $error("sign extension wrong");
endmodule // memspace_decode

// ==== dv/far_side_model.sv ====
// Far-side model: special register area and program window answering reads
`timescale 1ns/1ps
module far_side_model (
   input  wire logic        clk,
   input  wire logic        sfr_rd,
   input  wire logic [10:0] sfr_rd_addr,
   input  wire logic        win_rd,
   input  wire logic [14:0] win_rd_addr,
   output logic      [15:0] sfr_rd_data,
   output logic             sfr_rd_hit,
   output logic      [15:0] win_rd_data
);
   logic [15:0] idle_sfr = 16'h0f0f;
   logic [15:0] idle_win = 16'hf0f0;

   // Idle bus patterns keep flipping so stale data is never mistaken for an answer
   always @(posedge clk) begin
      idle_sfr <= ~idle_sfr;
      idle_win <= ~idle_win;
   end

   // Answer in the cycle the strobe stands; the decoder samples at its closing edge
   assign sfr_rd_hit  = sfr_rd && (sfr_rd_addr < 11'h100);
   assign sfr_rd_data = sfr_rd ? {5'h15, sfr_rd_addr} : idle_sfr;
   assign win_rd_data = win_rd ? {1'b1, win_rd_addr} : idle_win;
endmodule // far_side_model

// ==== dv/memspace_decode_bench.sv ====
// Self-checking bench of the memory space decoder
`timescale 1ns/1ps
module memspace_decode_bench;
   logic clk = 0, arst_n = 0, pc_step = 0, pc_step_down = 0, pc_load = 0, window_enable = 0;
   logic rd_req = 0, rd_byte = 0, rd_post_inc = 0, rd_post_dec = 0, wreg_req = 0;
   logic wr_req = 0, wr_byte = 0, wr_post_inc = 0, wr_post_dec = 0;
   logic [23:0] pc_load_addr = 0, pc_addr, pc_upper_addr;
   logic pc_in_vector_area, pc_in_ivt, pc_in_alt_ivt, rd_valid, sfr_rd, sfr_wr, win_rd;
   logic addr_error_trap, addr_error_on_write, wreg_valid, sfr_rd_hit;
   logic [15:0] rd_direct = 0, rd_ptr = 0, wr_direct = 0, wr_ptr = 0, wr_data = 0, wreg_old = 0;
   logic [15:0] rd_ptr_next, rd_data, wr_ptr_next, sfr_rd_data, sfr_wr_data, win_rd_data, wreg_new;
   logic [12:0] rd_near = 0, wr_near = 0;
   logic [10:0] sfr_rd_addr, sfr_wr_addr;
   logic [14:0] win_rd_addr;
   logic [1:0]  sfr_wr_be;
   logic [7:0]  wreg_byte = 0;
   memspace_pkg::ea_mode_t rd_mode = memspace_pkg::ea_direct, wr_mode = memspace_pkg::ea_direct;
   memspace_pkg::wreg_op_t wreg_op = memspace_pkg::wreg_pass;
   int mismatches = 0, checked = 0;

   memspace_decode dut_u (.*);
   far_side_model far_u (.clk(clk), .sfr_rd(sfr_rd), .sfr_rd_addr(sfr_rd_addr), .win_rd(win_rd),
      .win_rd_addr(win_rd_addr), .sfr_rd_data(sfr_rd_data), .sfr_rd_hit(sfr_rd_hit),
      .win_rd_data(win_rd_data));

   // 40 MHz clock
   always #12.5 clk = ~clk;

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("Checks %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Program counter step or load, then position flags
   task automatic pc_op(input logic s, input logic d, input logic l, input logic [23:0] a,
                        input logic [23:0] exp, input logic [2:0] fl);
      @(posedge clk);
      pc_step <= s; pc_step_down <= d; pc_load <= l; pc_load_addr <= a;
      @(posedge clk);
      pc_step <= 0; pc_load <= 0;
      #1;
      chk(pc_addr, exp);
      chk(pc_upper_addr, exp | 24'h000001);
      chk({pc_in_vector_area, pc_in_ivt, pc_in_alt_ivt}, fl);
   endtask

   // Data read: trap one cycle after, data two cycles after
   task automatic rd(input memspace_pkg::ea_mode_t m, input logic [15:0] ea, input logic b,
                     input logic [15:0] exp, input logic tr);
      @(posedge clk);
      rd_req <= 1; rd_byte <= b; rd_mode <= m; rd_direct <= ea; rd_near <= ea[12:0]; rd_ptr <= ea;
      @(posedge clk);
      rd_req <= 0;
      #1 chk(addr_error_trap, tr);
      @(posedge clk);
      #1 chk(rd_valid, 1'b1);
      chk(rd_data, exp);
   endtask

   // Data write: trap, write flag, register strobe and lanes one cycle after
   task automatic wr(input logic [15:0] ea, input logic b, input logic [15:0] d,
                     input logic [4:0] exp);
      @(posedge clk);
      wr_req <= 1; wr_byte <= b; wr_mode <= memspace_pkg::ea_direct; wr_direct <= ea; wr_data <= d;
      @(posedge clk);
      wr_req <= 0;
      #1 chk({addr_error_trap, addr_error_on_write, sfr_wr, sfr_wr ? sfr_wr_be : 2'b00}, exp);
   endtask

   // Pointer post-modify on both generators
   task automatic ptr(input logic [15:0] p, input logic i, input logic d, input logic b,
                      input logic [15:0] exp);
      @(posedge clk);
      rd_ptr <= p; wr_ptr <= p; rd_post_inc <= i; wr_post_inc <= i;
      rd_post_dec <= d; wr_post_dec <= d; rd_byte <= b; wr_byte <= b;
      @(posedge clk);
      #1 chk(rd_ptr_next, exp);
      chk(wr_ptr_next, exp);
   endtask

   // Working register byte update kinds
   task automatic wreg(input memspace_pkg::wreg_op_t op, input logic [15:0] old,
                       input logic [7:0] by, input logic [15:0] exp);
      @(posedge clk);
      wreg_req <= 1; wreg_op <= op; wreg_old <= old; wreg_byte <= by;
      @(posedge clk);
      wreg_req <= 0;
      #1 chk(wreg_valid, 1'b1);
      chk(wreg_new, exp);
   endtask

   // Watchdog against a hang
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      test_done();
   end

   initial begin
      repeat (10) @(posedge clk);
      chk(pc_addr, 24'h0);
      chk({pc_upper_addr, pc_in_vector_area}, {24'h1, 1'b1});
      arst_n <= 1;
      pc_op(1, 0, 0, 24'h0, 24'h000002, 3'b100);
      pc_op(1, 0, 0, 24'h0, 24'h000004, 3'b110);
      pc_op(0, 0, 1, 24'h0001ff, 24'h0001fe, 3'b101);
      pc_op(1, 0, 0, 24'h0, 24'h000200, 3'b000);
      pc_op(1, 1, 0, 24'h0, 24'h0001fe, 3'b101);
      pc_op(0, 0, 1, 24'h0000ff, 24'h0000fe, 3'b110);
      wr(16'h0800, 0, 16'h1234, 5'b00000);
      wr(16'h0801, 1, 16'h005a, 5'b00000);
      wr(16'h0801, 0, 16'hffff, 5'b11000);
      wr(16'h0013, 1, 16'h0077, 5'b00110);
      chk(sfr_wr_addr, 24'h000012);
      chk(sfr_wr_data, 24'h007777);
      wr(16'h8000, 0, 16'h4321, 5'b00000);
      rd(memspace_pkg::ea_direct, 16'h0800, 0, 16'h5a34, 0);
      rd(memspace_pkg::ea_direct, 16'h0801, 1, 16'h005a, 0);
      rd(memspace_pkg::ea_near, 16'h0800, 1, 16'h0034, 0);
      rd(memspace_pkg::ea_indirect, 16'h0800, 0, 16'h5a34, 0);
      rd(memspace_pkg::ea_direct, 16'h0803, 0, 16'h0000, 1);
      rd(memspace_pkg::ea_direct, 16'h4000, 0, 16'h0000, 0);
      rd(memspace_pkg::ea_direct, 16'h0010, 0, 16'ha810, 0);
      rd(memspace_pkg::ea_direct, 16'h0011, 1, 16'h00a8, 0);
      rd(memspace_pkg::ea_direct, 16'h0400, 0, 16'h0000, 0);
      window_enable <= 1;
      rd(memspace_pkg::ea_direct, 16'h8006, 0, 16'h8006, 0);
      window_enable <= 0;
      rd(memspace_pkg::ea_direct, 16'h8006, 0, 16'h0000, 0);
      ptr(16'h1000, 1, 0, 1, 16'h1001);
      ptr(16'h1000, 1, 0, 0, 16'h1002);
      ptr(16'h1000, 0, 1, 0, 16'h0ffe);
      ptr(16'h1000, 0, 0, 0, 16'h1000);
      wreg(memspace_pkg::wreg_byte_load, 16'h1234, 8'hab, 16'h12ab);
      wreg(memspace_pkg::wreg_sign_extend, 16'h3480, 8'h80, 16'hff80);
      wreg(memspace_pkg::wreg_zero_extend, 16'h3480, 8'h80, 16'h0080);
      wreg(memspace_pkg::wreg_pass, 16'h3480, 8'h80, 16'h3480);
      test_done();
   end
endmodule // memspace_decode_bench
